// >>> rtl/nco_pfc_pkg.sv
// Constants, host write codes and carrier types of the phase and frequency control section.
package nco_pfc_pkg;

  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int QUAD_W = 2;
  localparam int QUAD_FILL_W = 14;
  localparam int TARGET_W = 2;

  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
  localparam logic [QUAD_FILL_W-1:0] QUAD_FILL = 14'h0000;

  // Host write targets selected by load_target_select.
  typedef enum logic [TARGET_W-1:0] {
    TGT_FREQ_LOW = 2'h0,
    TGT_FREQ_HIGH = 2'h1,
    TGT_PHASE = 2'h2,
    TGT_RESERVED = 2'h3
  } target_t;

  // Host write pins as one group; the strobes are active low.
  typedef struct packed {
    logic [HALF_W-1:0] data;
    logic [TARGET_W-1:0] target;
    logic chipSelectN;
    logic writeStrobeN;
  } host_write_t;

  localparam host_write_t HOST_IDLE = '{data: 16'h0000, target: 2'h0, chipSelectN: 1'b1,
                                        writeStrobeN: 1'b1};

  // Registered control lines; every enable and clear is active low.
  typedef struct packed {
    logic centerEnN;
    logic offsetEnN;
    logic phaseEnN;
    logic timerEnN;
    logic phaseSel;
    logic [QUAD_W-1:0] quad;
    logic offsetClrN;
    logic loadN;
    logic timerLoadN;
  } ctrl_t;

  localparam ctrl_t CTRL_IDLE = '{centerEnN: 1'b1, offsetEnN: 1'b1, phaseEnN: 1'b1,
                                  timerEnN: 1'b1, phaseSel: 1'b1, quad: 2'h0,
                                  offsetClrN: 1'b1, loadN: 1'b1, timerLoadN: 1'b1};

endpackage : nco_pfc_pkg

// >>> rtl/nco_pin_sync.sv
// Two flip-flop synchroniser for a group of pins from outside the clock domain.
`timescale 1ns/1ps
module nco_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins and their synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end

endmodule : nco_pin_sync

// >>> rtl/nco_accumulator.sv
// Thirty-two bit accumulator with zeroable feedback and a registered active-low overflow.
`timescale 1ns/1ps
module nco_accumulator (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic syncClearN,
  // Control and step
  input wire logic feedbackZero,
  input wire logic [nco_pfc_pkg::WORD_W-1:0] step,
  // Accumulator state and overflow
  output logic [nco_pfc_pkg::WORD_W-1:0] acc,
  output logic overflowN
);

  logic [nco_pfc_pkg::WORD_W:0] sum;
  logic [nco_pfc_pkg::WORD_W-1:0] next_acc;
  logic next_overflowN;

  always_comb begin
    // Zeroed feedback loads the step itself and cannot overflow.
    sum = {1'b0, (feedbackZero ? nco_pfc_pkg::WORD_ZERO : acc)} + {1'b0, step};
    next_acc = sum[nco_pfc_pkg::WORD_W-1:0];
    next_overflowN = ~sum[nco_pfc_pkg::WORD_W];
    if (!syncClearN) begin
      next_acc = nco_pfc_pkg::WORD_ZERO;
      next_overflowN = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc <= nco_pfc_pkg::WORD_ZERO;
      overflowN <= 1'b1;
    end else begin
      acc <= next_acc;
      overflowN <= next_overflowN;
    end
  end

endmodule : nco_accumulator

// >>> rtl/nco_phase_frequency_control.sv
// Phase and frequency control section: host inputs, frequency, phase and both accumulators.
`timescale 1ns/1ps

// Notes on behaviour
// - Phase accumulator adds step every clock edge.
// - Overflow wraps modulo 2^32, carry exposed.
// - Step is center plus offset, modulo 2^32.
// - Wrap carry output is inverted overflow.
// - Time accumulator's only output: interval carry.
// - Phase offset added to accumulator top half.
// - Phase offset is sixteen bits, for PSK.
// - Argument maps linearly over full circle.
// - Frequency step is two's complement, sets sideband.
// - Words arrive sixteen bits per host write.
// - Chip select and write strobe load input register.
// - Target decode: low, high, phase, reserved.
// - Frequency halves form one shared 32-bit word.
// - Enable registered, target loads next edge.
// - Center register reloads while enable stays low.
// - Source high: phase register takes phase input.
// - Source low: quadrant bits on top, zeros below.
// - Capture on write strobe rising edge.
// - Load zeroes phase accumulator feedback.
// - Offset clear zeroes contribution, keeps register.
// - Timer load zeroes time feedback, stops carry.
module nco_phase_frequency_control (
  // Clock and resets
  input wire logic clock,
  input wire logic rstn,
  input wire logic syncClearN,
  // Host write pins, asynchronous to clock
  input wire logic [nco_pfc_pkg::HALF_W-1:0] controlWordBus,
  input wire logic [nco_pfc_pkg::TARGET_W-1:0] loadTargetSelect,
  input wire logic chipSelectN,
  input wire logic writeStrobeN,
  // Load enables, synchronous to clock, active low
  input wire logic centerFreqLoadEnN,
  input wire logic offsetFreqLoadEnN,
  input wire logic phaseOffsetLoadEnN,
  input wire logic timerStepLoadEnN,
  // Modulation and accumulator controls, synchronous to clock
  input wire logic phaseSourceSelect,
  input wire logic [nco_pfc_pkg::QUAD_W-1:0] quadrantShiftBits,
  input wire logic offsetPathClearN,
  input wire logic accumLoadN,
  input wire logic romBypassTimerLoadN,
  // Results
  output logic [nco_pfc_pkg::WORD_W-1:0] phaseArgument,
  output logic phaseWrapCarryN,
  output logic intervalCarryN
);

  nco_pfc_pkg::host_write_t hostPins;
  nco_pfc_pkg::host_write_t hostSync;
  logic writePrev;
  logic next_writePrev;
  logic writeRise;

  nco_pfc_pkg::ctrl_t ctrlReg;
  nco_pfc_pkg::ctrl_t next_ctrlReg;

  logic [nco_pfc_pkg::HALF_W-1:0] freqInputLow;
  logic [nco_pfc_pkg::HALF_W-1:0] freqInputHigh;
  logic [nco_pfc_pkg::HALF_W-1:0] phaseInput;
  logic [nco_pfc_pkg::HALF_W-1:0] next_freqInputLow;
  logic [nco_pfc_pkg::HALF_W-1:0] next_freqInputHigh;
  logic [nco_pfc_pkg::HALF_W-1:0] next_phaseInput;
  logic [nco_pfc_pkg::WORD_W-1:0] inputWord;

  logic [nco_pfc_pkg::WORD_W-1:0] centerFreq;
  logic [nco_pfc_pkg::WORD_W-1:0] offsetFreq;
  logic [nco_pfc_pkg::WORD_W-1:0] timerStep;
  logic [nco_pfc_pkg::HALF_W-1:0] phaseOffset;
  logic [nco_pfc_pkg::WORD_W-1:0] next_centerFreq;
  logic [nco_pfc_pkg::WORD_W-1:0] next_offsetFreq;
  logic [nco_pfc_pkg::WORD_W-1:0] next_timerStep;
  logic [nco_pfc_pkg::HALF_W-1:0] next_phaseOffset;

  logic [nco_pfc_pkg::WORD_W-1:0] phaseStep;
  logic [nco_pfc_pkg::WORD_W-1:0] phaseAcc;
  logic [nco_pfc_pkg::WORD_W-1:0] timeAcc;
  logic [nco_pfc_pkg::HALF_W-1:0] phaseTop;
  logic [nco_pfc_pkg::WORD_W-1:0] next_phaseArgument;

  // Host pins are synchronised as one group so data and strobes stay aligned.
  assign hostPins = '{data: controlWordBus, target: loadTargetSelect,
                      chipSelectN: chipSelectN, writeStrobeN: writeStrobeN};

  nco_pin_sync #(
    .WIDTH($bits(nco_pfc_pkg::host_write_t)),
    .RESET_VALUE(nco_pfc_pkg::HOST_IDLE)
  ) hostSyncInst (
    .clock(clock),
    .rstn(rstn),
    .d(hostPins),
    .q(hostSync)
  );

  // Rising edge of the synchronised write strobe. The data must still be valid when the
  // strobe rises, since the capture uses the data that crossed alongside it.
  always_comb begin
    next_writePrev = hostSync.writeStrobeN;
    writeRise = hostSync.writeStrobeN && !writePrev && !hostSync.chipSelectN;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      writePrev <= 1'b1;
    end else begin
      writePrev <= next_writePrev;
    end
  end

  // Input registers take one sixteen-bit half per host write.
  always_comb begin
    next_freqInputLow = freqInputLow;
    next_freqInputHigh = freqInputHigh;
    next_phaseInput = phaseInput;
    if (!syncClearN) begin
      next_freqInputLow = nco_pfc_pkg::HALF_ZERO;
      next_freqInputHigh = nco_pfc_pkg::HALF_ZERO;
      next_phaseInput = nco_pfc_pkg::HALF_ZERO;
    end else if (writeRise) begin
      unique case (nco_pfc_pkg::target_t'(hostSync.target))
        nco_pfc_pkg::TGT_FREQ_LOW: next_freqInputLow = hostSync.data;
        nco_pfc_pkg::TGT_FREQ_HIGH: next_freqInputHigh = hostSync.data;
        nco_pfc_pkg::TGT_PHASE: next_phaseInput = hostSync.data;
        nco_pfc_pkg::TGT_RESERVED: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      freqInputLow <= nco_pfc_pkg::HALF_ZERO;
      freqInputHigh <= nco_pfc_pkg::HALF_ZERO;
      phaseInput <= nco_pfc_pkg::HALF_ZERO;
    end else begin
      freqInputLow <= next_freqInputLow;
      freqInputHigh <= next_freqInputHigh;
      phaseInput <= next_phaseInput;
    end
  end

  assign inputWord = {freqInputHigh, freqInputLow};

  // Control lines are registered once; the registered copies steer the next edge.
  always_comb begin
    next_ctrlReg = '{centerEnN: centerFreqLoadEnN, offsetEnN: offsetFreqLoadEnN,
                     phaseEnN: phaseOffsetLoadEnN, timerEnN: timerStepLoadEnN,
                     phaseSel: phaseSourceSelect, quad: quadrantShiftBits,
                     offsetClrN: offsetPathClearN, loadN: accumLoadN,
                     timerLoadN: romBypassTimerLoadN};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= nco_pfc_pkg::CTRL_IDLE;
    end else begin
      ctrlReg <= next_ctrlReg;
    end
  end

  // Frequency, timer step and phase offset registers.
  always_comb begin
    next_centerFreq = centerFreq;
    next_offsetFreq = offsetFreq;
    next_timerStep = timerStep;
    next_phaseOffset = phaseOffset;
    if (!syncClearN) begin
      next_centerFreq = nco_pfc_pkg::WORD_ZERO;
      next_offsetFreq = nco_pfc_pkg::WORD_ZERO;
      next_timerStep = nco_pfc_pkg::WORD_ZERO;
      next_phaseOffset = nco_pfc_pkg::HALF_ZERO;
    end else begin
      if (!ctrlReg.centerEnN) begin
        next_centerFreq = inputWord;
      end
      if (!ctrlReg.offsetEnN) begin
        next_offsetFreq = inputWord;
      end
      if (!ctrlReg.timerEnN) begin
        next_timerStep = inputWord;
      end
      if (!ctrlReg.phaseEnN) begin
        if (ctrlReg.phaseSel) begin
          next_phaseOffset = phaseInput;
        end else begin
          next_phaseOffset = {ctrlReg.quad, nco_pfc_pkg::QUAD_FILL};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      centerFreq <= nco_pfc_pkg::WORD_ZERO;
      offsetFreq <= nco_pfc_pkg::WORD_ZERO;
      timerStep <= nco_pfc_pkg::WORD_ZERO;
      phaseOffset <= nco_pfc_pkg::HALF_ZERO;
    end else begin
      centerFreq <= next_centerFreq;
      offsetFreq <= next_offsetFreq;
      timerStep <= next_timerStep;
      phaseOffset <= next_phaseOffset;
    end
  end

  // A negative step is the same bit pattern modulo 2^32, so one unsigned adder serves
  // both sidebands and the phase simply rotates the other way.
  assign phaseStep = centerFreq + (ctrlReg.offsetClrN ? offsetFreq
                                                      : nco_pfc_pkg::WORD_ZERO);

  nco_accumulator phaseAccInst (
    .clock(clock),
    .rstn(rstn),
    .syncClearN(syncClearN),
    .feedbackZero(!ctrlReg.loadN),
    .step(phaseStep),
    .acc(phaseAcc),
    .overflowN(phaseWrapCarryN)
  );

  // Only the overflow of the time accumulator leaves the block.
  nco_accumulator timeAccInst (
    .clock(clock),
    .rstn(rstn),
    .syncClearN(syncClearN),
    .feedbackZero(!ctrlReg.timerLoadN),
    .step(timerStep),
    .acc(timeAcc),
    .overflowN(intervalCarryN)
  );

  // Phase adder: zero argument is zero degrees, full scale is just short of a full turn.
  always_comb begin
    phaseTop = phaseAcc[nco_pfc_pkg::WORD_W-1:nco_pfc_pkg::HALF_W] + phaseOffset;
    next_phaseArgument = {phaseTop, phaseAcc[nco_pfc_pkg::HALF_W-1:0]};
    if (!syncClearN) begin
      next_phaseArgument = nco_pfc_pkg::WORD_ZERO;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phaseArgument <= nco_pfc_pkg::WORD_ZERO;
    end else begin
      phaseArgument <= next_phaseArgument;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_accumAdds;
    (syncClearN && ctrlReg.loadN) |=> phaseAcc == 32'($past(phaseAcc) + $past(centerFreq)
      + ($past(ctrlReg.offsetClrN) ? $past(offsetFreq) : 32'h0000_0000));
  endproperty
  a_accumAdds: assert property (p_accumAdds)
    else $error("phase accumulator sum wrong");

  property p_wrapCarry;
    syncClearN |=> phaseWrapCarryN == !(33'($past(ctrlReg.loadN) ? $past(phaseAcc) : 32'h0)
      + 33'($past(phaseStep)) > 33'h0_FFFF_FFFF);
  endproperty
  a_wrapCarry: assert property (p_wrapCarry) else $error("wrap carry wrong");

  property p_loadZero;
    (syncClearN && !ctrlReg.loadN) |=> phaseAcc == $past(phaseStep) && phaseWrapCarryN;
  endproperty
  a_loadZero: assert property (p_loadZero)
    else $error("load did not restart accumulator");

  property p_timerLoad;
    (syncClearN && !ctrlReg.timerLoadN) |=> intervalCarryN && timeAcc == $past(timerStep);
  endproperty
  a_timerLoad: assert property (p_timerLoad) else $error("timer load left carry active");

  property p_centerLatency;
    (!centerFreqLoadEnN && syncClearN) ##1 syncClearN |=> centerFreq == $past(inputWord);
  endproperty
  a_centerLatency: assert property (p_centerLatency)
    else $error("center load latency wrong");

  property p_phaseSource;
    (syncClearN && !ctrlReg.phaseEnN) |=> phaseOffset == ($past(ctrlReg.phaseSel) ?
      $past(phaseInput) : {$past(ctrlReg.quad), 14'h0000});
  endproperty
  a_phaseSource: assert property (p_phaseSource)
    else $error("phase offset source wrong");

  property p_phaseArg;
    syncClearN |=> phaseArgument == {16'($past(phaseAcc[31:16]) + $past(phaseOffset)),
      $past(phaseAcc[15:0])};
  endproperty
  a_phaseArg: assert property (p_phaseArg) else $error("phase argument wrong");

  property p_writeLow;
    (syncClearN && writeRise && hostSync.target == 2'h0) |=> freqInputLow == $past(hostSync.data)
      && $stable(freqInputHigh) && $stable(phaseInput);
  endproperty
  a_writeLow: assert property (p_writeLow) else $error("low frequency half not written");

  property p_reserved;
    (syncClearN && writeRise && hostSync.target == 2'h3) |=> $stable(freqInputLow)
      && $stable(freqInputHigh) && $stable(phaseInput);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved write changed a register");

  property p_writeHigh;
    (syncClearN && writeRise && hostSync.target == 2'h1) |=> freqInputHigh == $past(hostSync.data)
      && $stable(freqInputLow) && $stable(phaseInput);
  endproperty
  a_writeHigh: assert property (p_writeHigh) else $error("high half not written");

  property p_writePhase;
    (syncClearN && writeRise && hostSync.target == 2'h2) |=> phaseInput == $past(hostSync.data)
      && $stable(freqInputLow) && $stable(freqInputHigh);
  endproperty
  a_writePhase: assert property (p_writePhase) else $error("phase input not written");

  property p_noSelect;
    (syncClearN && hostSync.chipSelectN) |=> $stable(freqInputLow) && $stable(freqInputHigh)
      && $stable(phaseInput);
  endproperty
  a_noSelect: assert property (p_noSelect) else $error("deselect wrote");

  property p_syncClear;
    !syncClearN |=> phaseAcc == 32'h0000_0000 && centerFreq == 32'h0000_0000
      && phaseOffset == 16'h0000 && phaseWrapCarryN && intervalCarryN;
  endproperty
  a_syncClear: assert property (p_syncClear) else $error("clear left state behind");

  property p_intervalCarry;
    (syncClearN && ctrlReg.timerLoadN) |=> timeAcc == 32'($past(timeAcc) + $past(timerStep))
      && intervalCarryN == !(33'($past(timeAcc)) + 33'($past(timerStep)) > 33'h0_FFFF_FFFF);
  endproperty
  a_intervalCarry: assert property (p_intervalCarry)
    else $error("interval carry wrong");

  // The clear gates only the adder input, so the stored offset must survive it.
  property p_offsetKept;
    (syncClearN && ctrlReg.offsetEnN) |=> $stable(offsetFreq);
  endproperty
  a_offsetKept: assert property (p_offsetKept) else $error("offset changed");

  c_phaseWrap: cover property (syncClearN ##1 !phaseWrapCarryN);
  c_intervalCarry: cover property (!intervalCarryN);
  c_reservedWrite: cover property (writeRise && hostSync.target == 2'h3);
  c_centerLoad: cover property (!ctrlReg.centerEnN ##1 centerFreq != 32'h0000_0000);

endmodule : nco_phase_frequency_control

// >>> tb/host_write_model.sv
// Host processor model that loads sixteen-bit halves over the control word bus.
`timescale 1ns/1ps
module host_write_model (
  // Clock
  input wire logic clock,
  // Host write pins
  output nco_pfc_pkg::host_write_t hw
);
  initial hw = nco_pfc_pkg::HOST_IDLE;

  // The strobe stays low six clocks and the data turns valid only halfway, so a capture
  // on the falling edge of the strobe would take the wrong word.
  task automatic write(input logic [1:0] tgt, input logic [15:0] d, input logic csN);
    @(negedge clock);
    hw.data = ~d;
    hw.target = tgt;
    hw.chipSelectN = csN;
    hw.writeStrobeN = 1'b0;
    repeat (3) @(negedge clock);
    hw.data = d;
    repeat (3) @(negedge clock);
    hw.writeStrobeN = 1'b1;
    @(negedge clock);
    // Released lines show the inverse, so a design that samples late sees wrong data.
    hw.data = ~d;
    hw.target = ~tgt;
    hw.chipSelectN = 1'b1;
    repeat (4) @(negedge clock);
  endtask : write
endmodule : host_write_model

// >>> tb/nco_phase_frequency_control_tb.sv
// Self-checking bench for the phase and frequency control section.
`timescale 1ns/1ps
module nco_phase_frequency_control_tb;
  logic clock;
  logic rstn;
  logic syncClearN;
  nco_pfc_pkg::host_write_t hw;
  nco_pfc_pkg::ctrl_t ct;
  logic [31:0] phaseArgument;
  logic phaseWrapCarryN;
  logic intervalCarryN;
  logic [31:0] expQ[$];
  int bad_count;
  int checked;
  logic [31:0] cWord;
  logic [31:0] oWord;
  logic [15:0] pWord;

  nco_phase_frequency_control nco_phase_frequency_control_inst (
    .clock(clock),
    .rstn(rstn),
    .syncClearN(syncClearN),
    .controlWordBus(hw.data),
    .loadTargetSelect(hw.target),
    .chipSelectN(hw.chipSelectN),
    .writeStrobeN(hw.writeStrobeN),
    .centerFreqLoadEnN(ct.centerEnN),
    .offsetFreqLoadEnN(ct.offsetEnN),
    .phaseOffsetLoadEnN(ct.phaseEnN),
    .timerStepLoadEnN(ct.timerEnN),
    .phaseSourceSelect(ct.phaseSel),
    .quadrantShiftBits(ct.quad),
    .offsetPathClearN(ct.offsetClrN),
    .accumLoadN(ct.loadN),
    .romBypassTimerLoadN(ct.timerLoadN),
    .phaseArgument(phaseArgument),
    .phaseWrapCarryN(phaseWrapCarryN),
    .intervalCarryN(intervalCarryN)
  );

  host_write_model host_write_model_inst (
    .clock(clock),
    .hw(hw)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [31:0] argOf(input logic [31:0] s, input logic [15:0] po);
    return {s[31:16] + po, s[15:0]};
  endfunction : argOf

  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk_arg(input logic [31:0] e);
    checked++;
    if (phaseArgument !== e) begin
      bad_count++;
      $display("[FAIL] %0t argument %h expected %h", $time, phaseArgument, e);
    end
  endtask : chk_arg

  task automatic chk_cnt(input int got, input int e);
    checked++;
    if (got != e) begin
      bad_count++;
      $display("[FAIL] %0t carry count %0d expected %0d", $time, got, e);
    end
  endtask : chk_cnt

  // Five edges cover enable register, target register and the accumulator pipeline.
  task automatic expect_arg(input logic [31:0] v);
    repeat (5) @(negedge clock);
    expQ.push_back(v);
  endtask : expect_arg

  task automatic wr32(input logic [31:0] w);
    host_write_model_inst.write(2'h0, w[15:0], 1'b0);
    host_write_model_inst.write(2'h1, w[31:16], 1'b0);
  endtask : wr32

  // Enables 0 to 3 are center, offset, phase and timer, the top four bits of the controls.
  task automatic ld(input int k);
    @(negedge clock);
    ct[9-k] = 1'b0;
    @(negedge clock);
    ct[9-k] = 1'b1;
  endtask : ld

  // A window of sixteen cycles holds whole periods of the quarter-turn and three-quarter-turn steps used here.
  task automatic count16(input int ePw, input int eIv);
    int pw;
    int iv;
    pw = 0;
    iv = 0;
    repeat (4) @(negedge clock);
    repeat (16) begin
      @(negedge clock);
      pw += int'(phaseWrapCarryN !== 1'b1);
      iv += int'(intervalCarryN !== 1'b1);
    end
    chk_cnt(pw, ePw);
    chk_cnt(iv, eIv);
  endtask : count16

  always @(posedge clock) begin
    if (expQ.size() > 0) begin
      chk_arg(expQ.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    close_out();
  end

  initial begin
    void'($urandom(42317));
    rstn = 1'b0;
    syncClearN = 1'b1;
    ct = nco_pfc_pkg::CTRL_IDLE;
    expect_arg(32'h0000_0000);
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    ct.loadN = 1'b0;
    cWord = $urandom;
    oWord = $urandom;
    pWord = 16'($urandom);
    $display("reset test done");
    wr32(cWord);
    ld(0);
    expect_arg(cWord);
    wr32(oWord);
    ld(1);
    expect_arg(cWord + oWord);
    ct.offsetClrN = 1'b0;
    expect_arg(cWord);
    ct.offsetClrN = 1'b1;
    expect_arg(cWord + oWord);
    $display("frequency test done");
    host_write_model_inst.write(2'h2, pWord, 1'b0);
    ld(2);
    expect_arg(argOf(cWord + oWord, pWord));
    ct.phaseSel = 1'b0;
    for (int q = 0; q < 4; q++) begin
      ct.quad = q[1:0];
      ld(2);
      expect_arg(argOf(cWord + oWord, {q[1:0], 14'h0000}));
    end
    ct.quad = 2'h0;
    ld(2);
    $display("phase offset test done");
    host_write_model_inst.write(2'h3, 16'($urandom), 1'b0);
    host_write_model_inst.write(2'h0, 16'($urandom), 1'b1);
    host_write_model_inst.write(2'h1, 16'($urandom), 1'b1);
    ld(0);
    expect_arg(oWord + oWord);
    ct.phaseSel = 1'b1;
    ld(2);
    expect_arg(argOf(oWord + oWord, pWord));
    $display("refused write test done");
    wr32(32'h2000_0000);
    ld(0);
    ld(1);
    ct.loadN = 1'b1;
    count16(4, 0);
    wr32(32'hC000_0000);
    ld(0);
    wr32(32'h0000_0000);
    ld(1);
    count16(12, 0);
    wr32(32'h4000_0000);
    ld(3);
    count16(12, 4);
    ct.timerLoadN = 1'b0;
    count16(12, 0);
    ct.timerLoadN = 1'b1;
    $display("accumulator test done");
    syncClearN = 1'b0;
    count16(0, 0);
    expect_arg(32'h0000_0000);
    syncClearN = 1'b1;
    ct.loadN = 1'b0;
    ld(0);
    expect_arg(32'h0000_0000);
    repeat (2) @(negedge clock);
    $display("clear test done");
    close_out();
  end
endmodule : nco_phase_frequency_control_tb
